//--- txc_asserts.sv
// Checker for the transmit client link between the MAC and client ends
module txc_asserts
(
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        txmac_clk_en,
  input wire logic        fifo_empty,
  input wire logic        mac_read,
  input wire logic        stat_en,
  input wire logic [30:0] stat_vec,
  input wire logic        tx_done,
  input wire logic        tx_discard
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Link properties
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // Frame end report
  sequence s_end;
    tx_done || tx_discard;
  endsequence
  property p_rd;
    $rose(mac_read) |-> !$past(fifo_empty);
  endproperty
  property p_stat;
    s_end |-> stat_en;
  endproperty
  property p_pulse;
    stat_en |=> !stat_en;
  endproperty
  property p_done;
    tx_done |=> !tx_done;
  endproperty
  property p_excl;
    !(tx_done && tx_discard);
  endproperty
  property p_disc;
    tx_discard |-> (stat_vec[5] || stat_vec[24] || stat_vec[25]);
  endproperty
  property p_en;
    !txmac_clk_en |=> $stable(mac_read);
  endproperty
  property p_cnt;
    stat_en && !stat_vec[6] |-> stat_vec[21:8] != 14'h0000;
  endproperty
  property p_done_ok;
    tx_done |-> !stat_vec[txc_pkg::BIT_URUN];
  endproperty
  property p_urun;
    stat_en && stat_vec[txc_pkg::BIT_URUN] |-> tx_discard;
  endproperty
  a_done_ok: assert property (p_done_ok) else $error("done after under-run");
  a_urun: assert property (p_urun) else $error("under-run without discard");
  a_rd: assert property (p_rd) else $error("read raised while empty");
  a_stat: assert property (p_stat) else $error("end without stat strobe");
  a_pulse: assert property (p_pulse) else $error("stat strobe too long");
  a_done: assert property (p_done) else $error("done too long");
  a_excl: assert property (p_excl) else $error("done with discard");
  a_disc: assert property (p_disc) else $error("discard without cause");
  a_en: assert property (p_en) else $error("read moved while disabled");
  a_cnt: assert property (p_cnt) else $error("zero byte count");
endmodule : txc_asserts

//--- txc_client.sv
// Client end: small frame FIFO that feeds the MAC transmit interface
module txc_client
(
  txc_if.client    lnk,
  input wire logic       clk_en,
  input wire logic [7:0] wr_data,
  input wire logic       wr_eof,
  input wire logic       wr_valid,
  output logic           wr_ready,
  input wire logic       wr_ctrl,
  input wire logic       pause_go,
  input wire logic [15:0] pause_val,
  output logic           frame_done,
  output logic           frame_drop
);
  localparam int DEPTH      = 64;
  localparam int AVAIL_FILL = 8; // Fill that starts a frame before its end byte
  logic [8:0] mem [DEPTH];
  logic [6:0] wp_reg;
  logic [6:0] rp_reg;
  logic [6:0] frames_reg;
  logic       ctrl_reg;
  logic [8:0] out_reg;
  logic       push;
  logic       pop;
  logic       last_push;
  logic       last_pop;
  logic [6:0] fill;

  // ----------------------------------------------------------------
  // Write side and read side
  // ----------------------------------------------------------------
  assign fill      = wp_reg - rp_reg;
  assign wr_ready  = fill != 7'(DEPTH);
  assign push      = wr_valid && wr_ready;
  assign pop       = lnk.mac_read && !lnk.fifo_empty && clk_en;
  assign last_push = push && wr_eof;
  assign last_pop  = pop && mem[rp_reg[5:0]][8];

  // Storage
  always_ff @(posedge lnk.clk_sys)
  begin
    if (push)
      mem[wp_reg[5:0]] <= {wr_eof, wr_data};
  end

  // Pointers, frame count, output register
  always_ff @(posedge lnk.clk_sys)
  begin
    if (lnk.srst)
    begin
      wp_reg     <= 7'h00;
      rp_reg     <= 7'h00;
      frames_reg <= 7'h00;
      ctrl_reg   <= 1'b0;
      out_reg    <= 9'h000;
    end
    else
    begin
      if (push)
        wp_reg <= wp_reg + 7'h01;
      if (last_push)
        ctrl_reg <= wr_ctrl;
      if (pop)
      begin
        rp_reg  <= rp_reg + 7'h01;
        out_reg <= mem[rp_reg[5:0]]; // One-cycle read latency
      end
      frames_reg <= frames_reg + 7'(last_push) - 7'(last_pop);
    end
  end

  // Link outputs
  assign lnk.txmac_clk_en = clk_en;
  assign lnk.fifo_empty   = wp_reg == rp_reg;
  assign lnk.fifo_data    = out_reg[7:0];
  assign lnk.fifo_eof     = out_reg[8];
  assign lnk.fifo_avail   = frames_reg != 7'h00 || fill >= 7'(AVAIL_FILL);
  assign lnk.fifo_ctrl    = ctrl_reg;
  assign lnk.pause_req    = pause_go;
  assign lnk.pause_time   = pause_go ? pause_val : 16'h0000;
  assign frame_done       = lnk.tx_done;
  assign frame_drop       = lnk.tx_discard;
endmodule : txc_client

//--- txc_if.sv
// Interface joining the MAC transmit side and the client FIFO side
interface txc_if
(
  input wire logic clk_sys,
  input wire logic srst
);
  logic        txmac_clk_en;
  logic [7:0]  fifo_data;
  logic        fifo_avail;
  logic        fifo_eof;
  logic        fifo_empty;
  logic [15:0] pause_time;
  logic        pause_req;
  logic        fifo_ctrl;
  logic        mac_read;
  logic        stat_en;
  logic [30:0] stat_vec;
  logic        tx_done;
  logic        tx_discard;

  modport mac
  (
    input  clk_sys, srst, txmac_clk_en, fifo_data, fifo_avail, fifo_eof, fifo_empty,
           pause_time, pause_req, fifo_ctrl,
    output mac_read, stat_en, stat_vec, tx_done, tx_discard
  );
  modport client
  (
    input  clk_sys, srst, mac_read, stat_en, stat_vec, tx_done, tx_discard,
    output txmac_clk_en, fifo_data, fifo_avail, fifo_eof, fifo_empty,
           pause_time, pause_req, fifo_ctrl
  );
endinterface : txc_if

//--- txc_mac.sv
// MAC end: transmit client interface reading the client FIFO
module txc_mac
(
  txc_if.mac              lnk,
  input wire logic        late_col,
  input wire logic        excess_col,
  input wire logic        mode_gbit,
  output logic [7:0]      net_data,
  output logic            net_en,
  output logic            net_err,
  output logic [15:0]     pause_sent
);
  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b000,
    ST_DELAY = 3'b001,
    ST_READ  = 3'b010,
    ST_PAUSE = 3'b011,
    ST_END   = 3'b100
  } txc_state_t;

  txc_state_t   state_reg;
  logic [7:0]   dly_reg;
  logic [13:0]  cnt_reg;
  logic         rd_reg;
  logic         vld_reg;
  logic         urun_reg;
  logic         ctrl_reg;
  logic         pause_reg;
  logic         lcol_reg;
  logic         xcol_reg;
  logic         ce;

  assign ce = lnk.txmac_clk_en;

  // Read request straight from its register
  assign lnk.mac_read = rd_reg;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Under-run: FIFO empty mid-frame, no read outstanding
  function automatic logic urun_hit
  (
    input logic        rd,
    input logic        empty,
    input logic [13:0] cnt
  );
    return !rd && empty && cnt != 14'h0000;
  endfunction : urun_hit

  // Frame ends in error: under-run or a collision
  function automatic logic frame_bad
  (
    input logic urun,
    input logic lcol,
    input logic xcol
  );
    return urun || lcol || xcol;
  endfunction : frame_bad

  // Statistics word for the frame just ended
  function automatic logic [30:0] stat_word
  (
    input logic        ctrl,
    input logic        urun,
    input logic        paused,
    input logic [13:0] cnt,
    input logic        lcol,
    input logic        xcol
  );
    logic [30:0] w;
    w = '0;
    w[txc_pkg::BIT_CTRL]                  = ctrl;
    w[txc_pkg::BIT_URUN]                  = urun;
    w[txc_pkg::BIT_PAUSE]                 = paused;
    w[txc_pkg::CNT_LSB +: txc_pkg::CNT_W] = cnt;
    w[txc_pkg::BIT_LATECOL]               = lcol;
    w[txc_pkg::BIT_XCOL]                  = xcol;
    return w;
  endfunction : stat_word

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge lnk.clk_sys)
  begin
    if (lnk.srst)
    begin
      state_reg <= ST_IDLE;
      dly_reg   <= 8'h00;
      cnt_reg   <= 14'h0000;
      rd_reg    <= 1'b0;
      urun_reg  <= 1'b0;
      ctrl_reg  <= 1'b0;
      vld_reg   <= 1'b0;
      pause_reg <= 1'b0;
      lcol_reg  <= 1'b0;
      xcol_reg  <= 1'b0;
      pause_sent <= 16'h0000;
    end
    else if (ce)
    begin
      unique case (state_reg)
        ST_IDLE:
        begin
          cnt_reg  <= 14'h0000;
          urun_reg <= 1'b0;
          lcol_reg <= 1'b0;
          xcol_reg <= 1'b0;
          rd_reg   <= 1'b0;
          vld_reg  <= 1'b0;
          dly_reg  <= 8'h00;
          pause_reg <= lnk.pause_req;
          if (lnk.pause_req)
          begin
            pause_sent <= lnk.pause_time;
            state_reg  <= ST_PAUSE;
          end
          else if (lnk.fifo_avail)
          begin
            ctrl_reg  <= lnk.fifo_ctrl;
            state_reg <= ST_DELAY;
          end
        end
        ST_DELAY:
        begin
          dly_reg <= dly_reg + 8'h01;
          if (dly_reg == 8'(txc_pkg::START_DLY - 1))
            state_reg <= ST_READ;
        end
        ST_READ:
        begin
          // request this cycle, byte valid next cycle
          // A byte queued right behind an end byte is popped once
          rd_reg  <= !lnk.fifo_empty && !(vld_reg && lnk.fifo_eof);
          vld_reg <= rd_reg && !lnk.fifo_empty;
          if (vld_reg)
          begin
            cnt_reg  <= cnt_reg + 14'h0001;
            lcol_reg <= lcol_reg | (!mode_gbit && late_col);
            xcol_reg <= xcol_reg | (!mode_gbit && excess_col);
            if (lnk.fifo_eof)
            begin
              rd_reg    <= 1'b0;
              vld_reg   <= 1'b0;
              state_reg <= ST_END;
            end
          end
          else if (urun_hit(rd_reg, lnk.fifo_empty, cnt_reg))
          begin
            urun_reg  <= 1'b1;
            state_reg <= ST_END;
          end
        end
        ST_PAUSE:
        begin
          dly_reg <= dly_reg + 8'h01;
          if (dly_reg == 8'(txc_pkg::PAUSE_LEN - 1))
            state_reg <= ST_END;
        end
        ST_END:
          state_reg <= ST_IDLE;
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Network side
  // ----------------------------------------------------------------
  always_ff @(posedge lnk.clk_sys)
  begin
    if (lnk.srst)
    begin
      net_data <= txc_pkg::RESET_BYTE;
      net_en   <= 1'b0;
      net_err  <= 1'b0;
    end
    else if (ce)
    begin
      net_en   <= state_reg == ST_READ && vld_reg;
      net_data <= lnk.fifo_data;
      net_err  <= state_reg == ST_READ && urun_hit(rd_reg, lnk.fifo_empty, cnt_reg);
    end
  end

  // ----------------------------------------------------------------
  // Status report at frame end
  // ----------------------------------------------------------------
  always_ff @(posedge lnk.clk_sys)
  begin
    if (lnk.srst)
    begin
      lnk.stat_en    <= 1'b0;
      lnk.stat_vec   <= 31'h00000000;
      lnk.tx_done    <= 1'b0;
      lnk.tx_discard <= 1'b0;
    end
    else
    begin
      // Strobes stand one clock even when the enable is slow
      lnk.stat_en    <= ce && state_reg == ST_END;
      lnk.tx_done    <= ce && state_reg == ST_END && !frame_bad(urun_reg, lcol_reg, xcol_reg);
      lnk.tx_discard <= ce && state_reg == ST_END && frame_bad(urun_reg, lcol_reg, xcol_reg);
      if (ce && state_reg == ST_END)
        lnk.stat_vec <= stat_word(ctrl_reg, urun_reg, pause_reg, cnt_reg, lcol_reg, xcol_reg);
    end
  end
endmodule : txc_mac

//--- txc_pkg.sv
// Package of shared constants for the transmit client FIFO interface
package txc_pkg;
  localparam int DATA_W        = 8;
  localparam int PAUSE_W       = 16;
  localparam int STAT_W        = 31;
  localparam int CNT_W         = 14;
  localparam int CNT_LSB       = 8;
  localparam int BIT_CTRL      = 0;
  localparam int BIT_URUN      = 5;
  localparam int BIT_PAUSE     = 6;
  localparam int BIT_DEFER     = 22;
  localparam int BIT_XDEFER    = 23;
  localparam int BIT_LATECOL   = 24;
  localparam int BIT_XCOL      = 25;
  localparam int START_DLY     = 4;
  localparam int PAUSE_LEN     = 60;
  localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage : txc_pkg

//--- txc_tb.sv
// Testbench joining the MAC and client ends of the transmit link
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 0, srst = 1, clk_en = 0, wr_eof = 0, wr_valid = 0, wr_ctrl = 0;
  logic        pause_go = 0, late_col = 0, excess_col = 0, mode_gbit = 1, dn, dc, ner = 0;
  logic        wr_ready, frame_done, frame_drop, net_en, net_err;
  logic [7:0]  wr_data = 8'h00, net_data, exp_b;
  logic [15:0] pause_val = 16'h0000, pause_sent;
  logic [30:0] sv;
  int          error_cnt = 0, cmp_count = 0, cyc = 0, div = 1, ph = 0, nb = 0, got = 0;
  always #25 clk_sys = ~clk_sys;
  txc_if txc_if_i (.clk_sys(clk_sys), .srst(srst));
  txc_client txc_client_i (.lnk(txc_if_i), .clk_en(clk_en), .wr_data(wr_data), .wr_eof(wr_eof),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_ctrl(wr_ctrl), .pause_go(pause_go),
    .pause_val(pause_val), .frame_done(frame_done), .frame_drop(frame_drop));
  txc_mac txc_mac_i (.lnk(txc_if_i), .late_col(late_col), .excess_col(excess_col), .mode_gbit(mode_gbit),
    .net_data(net_data), .net_en(net_en), .net_err(net_err), .pause_sent(pause_sent));
  txc_asserts txc_asserts_i (.clk_sys(clk_sys), .srst(srst), .txmac_clk_en(txc_if_i.txmac_clk_en),
    .fifo_empty(txc_if_i.fifo_empty), .mac_read(txc_if_i.mac_read), .stat_en(txc_if_i.stat_en),
    .stat_vec(txc_if_i.stat_vec), .tx_done(txc_if_i.tx_done), .tx_discard(txc_if_i.tx_discard));
  task chk(string nm, logic [15:0] e, logic [15:0] s);
    cmp_count++;
    if (s !== e)
    begin
      $display("unexpected %s exp %h got %h", nm, e, s);
      error_cnt++;
    end
  endtask : chk
  task finish_test;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  // Clock enable divider, one enabled cycle in div
  always @(posedge clk_sys)
  begin
    ph <= (ph + 1) % div;
    clk_en <= (ph == 0);
  end
  // Network byte monitor, stat capture and watchdog
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (net_en === 1'b1 && txc_if_i.txmac_clk_en === 1'b1)
    begin
      chk("net_data", 16'(exp_b), 16'(net_data));
      exp_b++;
      nb++;
    end
    if (txc_if_i.stat_en === 1'b1)
    begin
      sv <= txc_if_i.stat_vec;
      dn <= frame_done;
      dc <= frame_drop;
      got <= 1;
    end
    if (net_err === 1'b1)
      ner <= 1'b1;
    if (cyc == 30000)
    begin
      error_cnt++;
      finish_test;
    end
  end
  // One byte through the client write handshake
  task put(logic [7:0] b, logic e);
    wr_data <= b;
    wr_eof <= e;
    wr_valid <= 1'b1;
    do @(posedge clk_sys); while (wr_ready !== 1'b1);
  endtask : put
  task wait_end;
    for (int t = 0; t < 3000 && got == 0; t++) @(posedge clk_sys);
    @(posedge clk_sys);
  endtask : wait_end
  // Frame of n bytes: enable divider, speed, late and excess collision, type, under-run
  task frame(int n, int d, logic g, logic c, logic x, logic k, logic u);
    logic ed;
    ed = u || (!g && (c || x));
    div = d;
    mode_gbit <= g;
    late_col <= c;
    excess_col <= x;
    wr_ctrl <= k;
    nb = 0;
    exp_b = 8'h01;
    got = 0;
    ner = 1'b0;
    for (int i = 1; i <= n; i++) put(8'(i), i == n && !u);
    wr_valid <= 1'b0;
    wait_end();
    chk("bytes", 16'(n), 16'(nb));
    chk("count", 16'(n), 16'(sv[21:8]));
    chk("done", 16'(!ed), 16'(dn));
    chk("discard", 16'(ed), 16'(dc));
    chk("ctrl", 16'(k), 16'(sv[txc_pkg::BIT_CTRL]));
    chk("latecol", 16'(c && !g), 16'(sv[txc_pkg::BIT_LATECOL]));
    chk("xcol", 16'(x && !g), 16'(sv[txc_pkg::BIT_XCOL]));
    chk("urun", 16'(u), 16'(sv[txc_pkg::BIT_URUN]));
    chk("net_err", 16'(u), 16'(ner));
    $display("test frame of %0d bytes ends", n);
  endtask : frame
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    frame(5, 1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    frame(1, 1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    frame(4, 10, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    frame(8, 1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    frame(3, 1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    frame(3, 1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    frame(3, 1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    late_col <= 1'b0;
    excess_col <= 1'b0;
    pause_val <= 16'h1234;
    pause_go <= 1'b1;
    got = 0;
    repeat (3) @(posedge clk_sys);
    pause_go <= 1'b0;
    wait_end();
    chk("pause_sent", 16'h1234, pause_sent);
    chk("pause_bit", 16'h0001, 16'(sv[txc_pkg::BIT_PAUSE]));
    chk("pause_done", 16'h0001, 16'(dn));
    chk("pause_discard", 16'h0000, 16'(dc));
    $display("test pause ends");
    finish_test;
  end
endmodule : tb
